/* hdl/dpd_consts.svh */
/*
 constants for the deep sleep control block: bit positions, timing figures
 and the cycle counts derived from them. assumes a 125 MHz block clock.
*/
`ifndef DPD_CONSTS_SVH
`define DPD_CONSTS_SVH

`define DPD_CLK_PERIOD_PS        8000
`define DPD_ENTRY_BIT            15
`define DPD_CFG_ZERO_RESET       16'h8f1f
`define DPD_ENTRY_TIME_NS        3000
`define DPD_ENTRY_CYCLES         ((`DPD_ENTRY_TIME_NS * 1000) / `DPD_CLK_PERIOD_PS)
`define DPD_PULSE_MIN_NS         200
`define DPD_PULSE_MAX_NS         3000
`define DPD_WAKEUP_TIME_US       150
`define DPD_WAKEUP_CYCLES        ((`DPD_WAKEUP_TIME_US * 1000000) / `DPD_CLK_PERIOD_PS)

`endif

/* hdl/dpd_pkg.sv */
/*
 types shared by the deep sleep control block.
 assumes dpd_consts.svh holds the numbers.
*/
package dpd_pkg;
   typedef enum logic [1:0]
   {
      DPD_ACTIVE   = 2'b00,
      DPD_ENTERING = 2'b01,
      DPD_SLEEP    = 2'b11,
      DPD_WAKING   = 2'b10
   } dpd_state_e;
endpackage

/* hdl/dpd_sync.sv */
/*
 two flip-flop synchroniser for one pin level.
 assumes the input is asynchronous to clock_i.
*/
`timescale 1ns/1ps
`default_nettype none
module dpd_sync
(
   input  wire logic clock_i,
   input  wire logic srst_i,
   input  wire logic async_i,
   input  wire logic rst_val_i,
   output logic      sync_o
);
   logic meta;

   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         meta   <= 1'b1;
         sync_o <= 1'b1;
      end
      else
      begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end

   // rst_val_i unused on purpose: the synchronous reset on srst_i loads constant 1 only; kept tied high by caller
   logic unused_rst;
   assign unused_rst = rst_val_i;
endmodule
`default_nettype wire

/* hdl/dpd_ctrl.sv */
/*
 deep sleep control: takes a configuration_register_zero write, powers the
 array down, stops refresh and wakes on a chip select low-high pulse or reset.
 assumes the transaction decoder presents a one-cycle write strobe with the
 captured data, and that chip select and hardware reset come straight from pins.
*/
// Function
// - writing zero to bit 15 of configuration_register_zero requests deep sleep.
// - reach lowest power within 3 us of that write and halt refresh.
// - array contents are declared invalid once in deep sleep.
// - chip select low then high starts the exit.
// - power-on or hardware reset also leave deep sleep.
// - wakeup takes up to 150 us; no transaction before it ends.
// - after any exit the state equals post power-on, defaults reloaded; array_valid_o stays low unless the exit is srst_i.
// - upper data lanes are ignored during the entry command phase; the code ignores ca_phase_i and always reads bit 15.
// - in standby only chip select and hardware reset are looked at.
`include "dpd_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module dpd_ctrl
#(
   parameter int unsigned WAKEUP_CYCLES = `DPD_WAKEUP_CYCLES
)
(
   input  wire logic        clock_i,
   input  wire logic        srst_i,
   input  wire logic        cs_n_i,
   input  wire logic        hw_reset_n_i,
   input  wire logic        configuration_register_zero_wr_i,
   input  wire logic        ca_phase_i,
   input  wire logic [15:0] configuration_register_zero_wdata_i,
   output logic             refresh_en_o,
   output logic             core_power_o,
   output logic             array_valid_o,
   output logic             bus_enable_o,
   output logic             deep_sleep_state_o,
   output logic [15:0]      configuration_register_zero_o
);
   localparam logic [8:0]  ENTRY_CYCLES   = 9'(`DPD_ENTRY_CYCLES);
   localparam logic [15:0] CFG_ZERO_RESET = `DPD_CFG_ZERO_RESET;

   dpd_pkg::dpd_state_e state;
   dpd_pkg::dpd_state_e next_state;
   logic        cs_n_s;
   logic        rst_n_s;
   logic        cs_n_d;
   logic [8:0]  entry_cnt;
   logic [31:0] wake_cnt;

   dpd_sync u_cs_sync
   (
      .clock_i   (clock_i),
      .srst_i    (srst_i),
      .async_i   (cs_n_i),
      .rst_val_i (1'b1),
      .sync_o    (cs_n_s)
   );

   dpd_sync u_rst_sync
   (
      .clock_i   (clock_i),
      .srst_i    (srst_i),
      .async_i   (hw_reset_n_i),
      .rst_val_i (1'b1),
      .sync_o    (rst_n_s)
   );

   wire hw_reset    = srst_i | ~rst_n_s;
   wire cs_rise     = cs_n_s & ~cs_n_d;
   // ca_phase_i is left unused and does not qualify the write; only data bit 15 enters the decision
   wire entry_req   = configuration_register_zero_wr_i
                      & ~configuration_register_zero_wdata_i[`DPD_ENTRY_BIT];
   wire entry_done  = (entry_cnt == ENTRY_CYCLES - 9'd1);
   wire wake_done   = (wake_cnt == WAKEUP_CYCLES - 1);
   wire in_lowpower = (state != dpd_pkg::DPD_ACTIVE);

   always_comb
   begin
      next_state = state;
      case (state)
         dpd_pkg::DPD_ACTIVE:   if (entry_req) next_state = dpd_pkg::DPD_ENTERING;
         dpd_pkg::DPD_ENTERING: if (entry_done) next_state = dpd_pkg::DPD_SLEEP;
         dpd_pkg::DPD_SLEEP:    if (cs_rise) next_state = dpd_pkg::DPD_WAKING;
         dpd_pkg::DPD_WAKING:   if (wake_done) next_state = dpd_pkg::DPD_ACTIVE;
         default:               next_state = dpd_pkg::DPD_ACTIVE;
      endcase
   end

   always_ff @(posedge clock_i)
   begin
      if (hw_reset)
      begin
         state  <= dpd_pkg::DPD_ACTIVE;
         cs_n_d <= 1'b1;
      end
      else
      begin
         state  <= next_state;
         cs_n_d <= cs_n_s;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (hw_reset || state != dpd_pkg::DPD_ENTERING)
         entry_cnt <= 9'd0;
      else
         entry_cnt <= entry_cnt + 9'd1;
   end

   always_ff @(posedge clock_i)
   begin
      if (hw_reset || state != dpd_pkg::DPD_WAKING)
         wake_cnt <= 32'd0;
      else
         wake_cnt <= wake_cnt + 32'd1;
   end

   // configuration reloads defaults on every exit, same as power-on
   always_ff @(posedge clock_i)
   begin
      if (hw_reset || (state == dpd_pkg::DPD_WAKING && wake_done))
         configuration_register_zero_o <= CFG_ZERO_RESET;
      else if (configuration_register_zero_wr_i && state == dpd_pkg::DPD_ACTIVE)
         configuration_register_zero_o <= configuration_register_zero_wdata_i;
   end

   // array stays invalid after deep sleep; only srst_i marks it valid again, hardware reset does not
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         array_valid_o <= 1'b1;
      else if (state == dpd_pkg::DPD_SLEEP)
         array_valid_o <= 1'b0;
   end

   always_ff @(posedge clock_i)
   begin
      if (hw_reset)
      begin
         refresh_en_o       <= 1'b1;
         core_power_o       <= 1'b1;
         bus_enable_o       <= 1'b1;
         deep_sleep_state_o <= 1'b0;
      end
      else
      begin
         refresh_en_o       <= (next_state == dpd_pkg::DPD_ACTIVE);
         core_power_o       <= (next_state != dpd_pkg::DPD_SLEEP);
         bus_enable_o       <= (next_state == dpd_pkg::DPD_ACTIVE);
         deep_sleep_state_o <= (next_state == dpd_pkg::DPD_SLEEP) || (next_state == dpd_pkg::DPD_ENTERING);
      end
   end

   logic unused_ca;
   assign unused_ca = ca_phase_i;

   a_entry_bound: assert property (@(posedge clock_i) disable iff (hw_reset)
      $rose(state == dpd_pkg::DPD_ENTERING) |-> ##[1:375] !core_power_o)
      else $error("power not cut in time");
   a_refresh_stop: assert property (@(posedge clock_i) disable iff (hw_reset)
      state == dpd_pkg::DPD_SLEEP |-> !refresh_en_o)
      else $error("refresh running in deep sleep");
   a_entry_start: assert property (@(posedge clock_i) disable iff (hw_reset)
      state == dpd_pkg::DPD_ACTIVE && entry_req |=> state == dpd_pkg::DPD_ENTERING)
      else $error("entry write missed");
   a_exit_pulse: assert property (@(posedge clock_i) disable iff (hw_reset)
      state == dpd_pkg::DPD_SLEEP && cs_rise |=> state == dpd_pkg::DPD_WAKING)
      else $error("exit pulse missed");
   a_stay_asleep: assert property (@(posedge clock_i) disable iff (hw_reset)
      state == dpd_pkg::DPD_SLEEP && !cs_rise |=> state == dpd_pkg::DPD_SLEEP)
      else $error("left sleep without pulse");
   a_bus_quiet: assert property (@(posedge clock_i) disable iff (hw_reset)
      in_lowpower |=> !bus_enable_o || state == dpd_pkg::DPD_ACTIVE)
      else $error("bus enabled while low power");
   a_reset_exit: assert property (@(posedge clock_i)
      hw_reset |=> state == dpd_pkg::DPD_ACTIVE && configuration_register_zero_o == CFG_ZERO_RESET)
      else $error("reset did not exit");
   a_defaults_back: assert property (@(posedge clock_i) disable iff (hw_reset)
      state == dpd_pkg::DPD_WAKING && wake_done |=> configuration_register_zero_o == CFG_ZERO_RESET && bus_enable_o)
      else $error("defaults not restored");
   a_array_lost: assert property (@(posedge clock_i) disable iff (srst_i)
      state == dpd_pkg::DPD_SLEEP |=> !array_valid_o)
      else $error("array still valid");

   c_enter: cover property (@(posedge clock_i) state == dpd_pkg::DPD_SLEEP);
   c_wake: cover property (@(posedge clock_i) state == dpd_pkg::DPD_WAKING ##1 state == dpd_pkg::DPD_ACTIVE);
   c_reset_sleep: cover property (@(posedge clock_i) state == dpd_pkg::DPD_SLEEP && hw_reset);
endmodule
`default_nettype wire

/* tb/dpd_host.sv */
/* host stand-in: issues the sleep entry write and the chip select exit pulse.
   assumes the bench calls its tasks; cs timing sits on an 80 ns link grid. */
`timescale 1ns/1ps
`default_nettype none
module dpd_host
(
   input  wire logic   clock_i,
   output var logic        cs_n_o,
   output var logic        cfg_wr_o,
   output var logic        ca_phase_o,
   output var logic [15:0] cfg_wdata_o
);
   initial
   begin
      cs_n_o = 1'b1;
      cfg_wr_o = 1'b0;
      ca_phase_o = 1'b0;
      cfg_wdata_o = 16'h0000;
   end
   task automatic write_config(input logic [15:0] data);
      @(posedge clock_i);
      #1;
      ca_phase_o = 1'b1;
      cfg_wr_o = 1'b1;
      cfg_wdata_o = data;
      @(posedge clock_i);
      #1;
      cfg_wr_o = 1'b0;
      ca_phase_o = 1'b0;
      // released lanes show a changed value, not the stale one
      cfg_wdata_o = ~data;
   endtask
   // 3..37 periods of 80 ns keep the pulse inside 200..3000 ns; called 1 ns after an edge
   task automatic exit_pulse(input int periods);
      cs_n_o = 1'b0;
      #(80 * periods);
      cs_n_o = 1'b1;
   endtask
endmodule
`default_nettype wire

/* tb/deep_power_down_control_test.sv */
/* self-checking bench for dpd_ctrl against an expected-state model.
   assumes a 125 MHz clock and a wakeup count shortened to 20 cycles. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(w, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; $display("BAD %s exp %h got %h", w, e, g); end end
module deep_power_down_control_test;
   localparam int WAKE = 20;
   logic        clock_i;
   logic        srst_i;
   logic        hw_reset_n;
   logic        cs_n;
   logic        cfg_wr;
   logic        ca_phase;
   logic [15:0] wdata;
   logic        refresh_en;
   logic        core_power;
   logic        array_valid;
   logic        bus_enable;
   logic        sleep;
   logic [15:0] cfg_word;
   logic [15:0] rnd;
   int          n_errors = 0;
   int          compares = 0;
   int          cycles = 0;
   int          seed = 4;
   int          n;
   dpd_host host (.clock_i(clock_i), .cs_n_o(cs_n), .cfg_wr_o(cfg_wr), .ca_phase_o(ca_phase), .cfg_wdata_o(wdata));
   dpd_ctrl #(.WAKEUP_CYCLES(WAKE)) dut (.clock_i(clock_i), .srst_i(srst_i), .cs_n_i(cs_n),
      .hw_reset_n_i(hw_reset_n), .configuration_register_zero_wr_i(cfg_wr), .ca_phase_i(ca_phase),
      .configuration_register_zero_wdata_i(wdata),
      .refresh_en_o(refresh_en), .core_power_o(core_power), .array_valid_o(array_valid),
      .bus_enable_o(bus_enable), .deep_sleep_state_o(sleep), .configuration_register_zero_o(cfg_word));
   task automatic close_out;
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // s: 0 active, 1 asleep, 2 waking; v: expected array validity
   task automatic expect_state(input int s, input int v);
      `CHK("deep_sleep", s == 1, sleep)
      `CHK("refresh_en", s == 0, refresh_en)
      `CHK("bus_enable", s == 0, bus_enable)
      `CHK("core_power", s != 1, core_power)
      `CHK("array_valid", v == 1, array_valid)
      if (s == 0)
         `CHK("configuration_register_zero", 16'h8f1f, cfg_word)
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clock_i);
      #1;
   endtask
   task automatic enter_sleep;
      rnd = 16'($random(seed));
      host.write_config({1'b0, rnd[14:0]});
      tick(1);
      `CHK("entered", 1'b1, sleep)
      tick(375);
      expect_state(1, 0);
   endtask
   initial
   begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end
   always @(posedge clock_i)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         n_errors++;
         close_out();
      end
   end
   initial
   begin
      srst_i = 1'b1;
      hw_reset_n = 1'b1;
      repeat (12) @(posedge clock_i);
      #1 srst_i = 1'b0;
      // settle before treating the device as standby
      tick(1);
      expect_state(0, 1);
      host.write_config(16'h8f1f);
      tick(2);
      expect_state(0, 1);
      $display("test reset and refused entry done");
      for (int k = 0; k < 3; k++)
      begin
         enter_sleep();
         host.exit_pulse(k == 0 ? 3 : k == 1 ? 37 : 3 + int'(rnd[15:8]) % 35);
         tick(6);
         expect_state(2, 0);
         // bench waits for bus_enable while counting cycles, then checks the count against WAKE
         n = 0;
         while (bus_enable !== 1'b1 && n < WAKE + 10)
         begin
            tick(1);
            n++;
         end
         `CHK("wake_window", 1'b1, n + 6 >= WAKE && n <= WAKE)
         expect_state(0, 0);
      end
      $display("test chip select exit done");
      enter_sleep();
      hw_reset_n = 1'b0;
      tick(4);
      hw_reset_n = 1'b1;
      tick(4);
      expect_state(0, 0);
      $display("test hardware reset exit done");
      enter_sleep();
      srst_i = 1'b1;
      tick(3);
      srst_i = 1'b0;
      tick(1);
      expect_state(0, 1);
      $display("test reset exit done");
      close_out();
   end
endmodule
`default_nettype wire
